// ==== hw/ddr_wtp_pkg.sv ====
// constants and types for the ddr write-turnaround and precharge block
package ddr_wtp_pkg;
    localparam int NBANK                = 4;
    localparam int CNT_W                = 8;
    localparam int ADDR_W               = 13;
    localparam int COL_W                = 10;
    localparam int DQ_W                 = 16;
    localparam int PRECHARGE_SELECT_BIT = 10;
    localparam int WB_ADR_W             = 4;
    // register byte offsets
    localparam logic [3:0] CFG_OFS  = 4'h0;
    localparam logic [3:0] TIME_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    // field positions
    localparam int TRP_LSB   = 0;
    localparam int ACTIVATE_TO_PRECHARGE_MIN_LSB  = 8;
    localparam int TWR_LSB   = 16;
    localparam int ST_ACT_BIT = 8;
    localparam int ST_AP_LSB = 12;
    // reset values, timers in link clock cycles
    localparam logic [1:0] BL_RST   = 2'h2;
    localparam logic [7:0] TRP_RST  = 8'h03;
    localparam logic [7:0] ACTIVATE_TO_PRECHARGE_MIN_RST = 8'h08;
    localparam logic [7:0] TWR_RST  = 8'h02;
    // burst length codes
    localparam logic [1:0] BL_CODE_2 = 2'h1;
    localparam logic [1:0] BL_CODE_4 = 2'h2;
    localparam logic [1:0] BL_CODE_8 = 2'h3;
    localparam logic [3:0] BL_ELEM_2 = 4'h2;
    localparam logic [3:0] BL_ELEM_4 = 4'h4;
    localparam logic [3:0] BL_ELEM_8 = 4'h8;
    // command code is {row strobe, column strobe, write enable}, all active low
    typedef enum logic [2:0] {
        CMD_NOP   = 3'b111,
        CMD_ACT   = 3'b011,
        CMD_READ  = 3'b101,
        CMD_WRITE = 3'b100,
        CMD_PRE   = 3'b010
    } cmd_t;
    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_ACT  = 2'b01,
        B_PRE  = 2'b10
    } bank_state_t;
endpackage

// ==== hw/ddr_wr_turnaround.sv ====
// ddr device-side write capture, bank precharge and auto precharge logic
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ddr_wr_turnaround
    import ddr_wtp_pkg::*;
#(
    parameter int BANKS = NBANK,
    parameter int CW    = CNT_W
) (
    // system
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // wishbone slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [ddr_wtp_pkg::WB_ADR_W-1:0] adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // memory link pins
    input  wire logic                          ck_i,
    input  wire logic                          cs_n_i,
    input  wire logic                          ras_n_i,
    input  wire logic                          cas_n_i,
    input  wire logic                          we_n_i,
    input  wire logic [ddr_wtp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                          bank_select_low_i,
    input  wire logic                          bank_select_high_i,
    input  wire logic [ddr_wtp_pkg::DQ_W-1:0]  dq_i,
    input  wire logic [1:0]                    data_mask_input_i,
    input  wire logic                          lower_byte_strobe_i,
    input  wire logic                          upper_byte_strobe_i,
    // array write port and bank view
    output logic                               wr_valid_o,
    output logic [1:0]                         wr_bank_o,
    output logic [ddr_wtp_pkg::COL_W-1:0]      wr_col_o,
    output logic [ddr_wtp_pkg::DQ_W-1:0]       wr_data_o,
    output logic [1:0]                         wr_be_o,
    output logic [2*ddr_wtp_pkg::NBANK-1:0]    bank_state_o
);
    import ddr_wtp_pkg::*;

    if (BANKS != NBANK || CW < 4) begin : g_chk
        $error("unsupported bank count or counter width");
    end

    function automatic cmd_t decode(input logic cs_n, input logic [2:0] rcw);
        cmd_t c;
        c = CMD_NOP;
        if (!cs_n) begin
            unique case (rcw)
                CMD_ACT:   c = CMD_ACT;
                CMD_READ:  c = CMD_READ;
                CMD_WRITE: c = CMD_WRITE;
                CMD_PRE:   c = CMD_PRE;
                default:   c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic [3:0] bl_elems(input logic [1:0] code);
        logic [3:0] n;
        n = BL_ELEM_2;
        if (code == BL_CODE_4) n = BL_ELEM_4;
        if (code == BL_CODE_8) n = BL_ELEM_8;
        return n;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    // two-stage synchronisers; only the second stage is read
    // command pins, address, bank select, data, mask, strobes
    localparam int SY_W = 5 + ADDR_W + 2 + DQ_W + 2 + 2;
    logic [SY_W-1:0] sy_in;
    logic [SY_W-1:0] sy1_reg;
    logic [SY_W-1:0] sy2_reg;
    logic            ck_s, cs_s, ras_s, cas_s, we_s, ls_s, us_s;
    logic [ADDR_W-1:0] addr_s;
    logic [1:0]      ba_s;
    logic [DQ_W-1:0] dq_s;
    logic [1:0]      dm_s;
    logic            ck_d_reg, ls_d_reg, us_d_reg;

    assign sy_in = {ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, addr_i,
                    bank_select_high_i, bank_select_low_i, dq_i, data_mask_input_i,
                    lower_byte_strobe_i, upper_byte_strobe_i};
    assign {ck_s, cs_s, ras_s, cas_s, we_s, addr_s, ba_s, dq_s, dm_s, ls_s, us_s} = sy2_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sy1_reg  <= '0;
            sy2_reg  <= '0;
            ck_d_reg <= 1'b0;
            ls_d_reg <= 1'b0;
            us_d_reg <= 1'b0;
        end else begin
            sy1_reg  <= sy_in;
            sy2_reg  <= sy1_reg;
            ck_d_reg <= ck_s;
            ls_d_reg <= ls_s;
            us_d_reg <= us_s;
        end
    end

    logic ck_rise, l_edge, u_edge, l_rise, u_rise, a10;
    cmd_t cmd;
    assign ck_rise = ck_s & ~ck_d_reg;
    assign l_edge  = ls_s ^ ls_d_reg;
    assign u_edge  = us_s ^ us_d_reg;
    assign l_rise  = ls_s & ~ls_d_reg;
    assign u_rise  = us_s & ~us_d_reg;
    assign a10     = addr_s[PRECHARGE_SELECT_BIT];
    assign cmd     = ck_rise ? decode(cs_s, {ras_s, cas_s, we_s}) : CMD_NOP;

    // register file
    logic [1:0]  bl_reg, bl_next;
    logic [31:0] time_reg, time_next;
    logic        ack_reg, ack_next;
    logic [31:0] rd_reg, rd_next;
    logic [CW-1:0] precharge_period, activate_to_precharge_min, write_recovery_time;
    logic [3:0]  blen;
    logic        burst_reg;
    logic [BANKS-1:0] ap_reg;
    bank_state_t st_reg [BANKS];

    assign precharge_period  = CW'(time_reg[TRP_LSB +: 8]);
    assign activate_to_precharge_min = CW'(time_reg[ACTIVATE_TO_PRECHARGE_MIN_LSB +: 8]);
    assign write_recovery_time  = CW'(time_reg[TWR_LSB +: 8]);
    assign blen = bl_elems(bl_reg);

    always_comb begin
        bl_next   = bl_reg;
        time_next = time_reg;
        rd_next   = rd_reg;
        ack_next  = cyc_i & stb_i & ~ack_reg;
        if (ack_next) begin
            rd_next = '0;
            unique case (adr_i)
                CFG_OFS: begin
                    rd_next[1:0] = bl_reg;
                    if (we_i) bl_next = 2'(merge({30'h0, bl_reg}, dat_i, sel_i));
                end
                TIME_OFS: begin
                    rd_next = time_reg;
                    if (we_i) time_next = merge(time_reg, dat_i, sel_i);
                end
                STAT_OFS: begin
                    for (int b = 0; b < BANKS; b++) rd_next[2*b +: 2] = st_reg[b];
                    rd_next[ST_ACT_BIT] = burst_reg;
                    rd_next[ST_AP_LSB +: BANKS] = ap_reg;
                end
                default: rd_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bl_reg   <= BL_RST;
            time_reg <= {8'h00, TWR_RST, ACTIVATE_TO_PRECHARGE_MIN_RST, TRP_RST};
            ack_reg  <= 1'b0;
            rd_reg   <= '0;
        end else begin
            bl_reg   <= bl_next;
            time_reg <= time_next;
            ack_reg  <= ack_next;
            rd_reg   <= rd_next;
        end
    end
    assign ack_o = ack_reg;
    assign dat_o = rd_reg;

    // per-bank state and timers
    bank_state_t   st_next [BANKS];
    logic [CW-1:0] ras_reg [BANKS], ras_next [BANKS];
    logic [CW-1:0] rp_reg  [BANKS], rp_next  [BANKS];
    logic [CW-1:0] apw_reg [BANKS], apw_next [BANKS];
    logic [BANKS-1:0] ap_next;
    logic [2*BANKS-1:0] bso_next, bso_reg;

    always_comb begin
        for (int b = 0; b < BANKS; b++) begin
            st_next[b]  = st_reg[b];
            ras_next[b] = ras_reg[b];
            rp_next[b]  = rp_reg[b];
            apw_next[b] = apw_reg[b];
            ap_next[b]  = ap_reg[b];
            if (ck_rise) begin
                if (ras_reg[b] != '0) ras_next[b] = ras_reg[b] - 1'b1;
                if (rp_reg[b] != '0)  rp_next[b]  = rp_reg[b] - 1'b1;
                if (apw_reg[b] != '0) apw_next[b] = apw_reg[b] - 1'b1;
            end
            unique case (st_reg[b])
                B_IDLE: begin
                    if (cmd == CMD_ACT && ba_s == 2'(b)) begin
                        st_next[b]  = B_ACT;
                        ras_next[b] = activate_to_precharge_min;
                    end
                end
                B_ACT: begin
                    // auto precharge waits for burst end and the activate minimum
                    if (ap_reg[b] && apw_reg[b] == '0 && ras_reg[b] == '0) begin
                        st_next[b] = B_PRE;
                        rp_next[b] = precharge_period;
                        ap_next[b] = 1'b0;
                    end else if (cmd == CMD_PRE && (a10 || ba_s == 2'(b))) begin
                        st_next[b] = B_PRE;
                        rp_next[b] = precharge_period;
                        ap_next[b] = 1'b0;
                    end else if ((cmd == CMD_READ || cmd == CMD_WRITE) && ba_s == 2'(b)
                                 && a10) begin
                        ap_next[b]  = 1'b1;
                        apw_next[b] = (cmd == CMD_READ) ? CW'(blen >> 1)
                                    : CW'(blen >> 1) + write_recovery_time + CW'(1);
                    end
                end
                B_PRE: begin
                    // a precharge here is ignored; bank idles once the period runs out
                    if (rp_reg[b] == '0) st_next[b] = B_IDLE;
                end
                default: st_next[b] = B_IDLE;
            endcase
            bso_next[2*b +: 2] = st_next[b];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int b = 0; b < BANKS; b++) begin
                st_reg[b]  <= B_IDLE;
                ras_reg[b] <= '0;
                rp_reg[b]  <= '0;
                apw_reg[b] <= '0;
            end
            ap_reg  <= '0;
            bso_reg <= '0;
        end else begin
            st_reg  <= st_next;
            ras_reg <= ras_next;
            rp_reg  <= rp_next;
            apw_reg <= apw_next;
            ap_reg  <= ap_next;
            bso_reg <= bso_next;
        end
    end
    assign bank_state_o = bso_reg;

    // write burst capture; both lanes share the column counter, so the upper
    // strobe must edge in the same sample as the lower one
    logic          armed_reg, armed_next, burst_next;
    logic [3:0]    rem_reg, rem_next;
    logic [COL_W-1:0] col_reg, col_next;
    logic [1:0]    bk_reg, bk_next;
    logic          l_take, u_take;
    logic          wv_next;
    logic [1:0]    wbe_next, wbk_next;
    logic [COL_W-1:0] wc_next;
    logic [DQ_W-1:0]  wd_next;

    assign l_take = burst_reg & l_edge & (armed_reg | l_rise);
    assign u_take = burst_reg & u_edge & (armed_reg | u_rise);

    always_comb begin
        burst_next = burst_reg;
        armed_next = armed_reg;
        rem_next   = rem_reg;
        col_next   = col_reg;
        bk_next    = bk_reg;
        wbe_next   = {u_take & ~dm_s[1], l_take & ~dm_s[0]};
        wv_next    = |wbe_next;
        wbk_next   = wr_bank_o;
        wc_next    = wr_col_o;
        wd_next    = wr_data_o;
        if (l_take | u_take) begin
            wbk_next = bk_reg;
            wc_next  = col_reg;
            if (l_take) wd_next[DQ_W/2-1:0]    = dq_s[DQ_W/2-1:0];
            if (u_take) wd_next[DQ_W-1:DQ_W/2] = dq_s[DQ_W-1:DQ_W/2];
        end
        if (l_take) begin
            armed_next = 1'b1;
            col_next   = col_reg + 1'b1;
            rem_next   = rem_reg - 1'b1;
            if (rem_reg == 4'h1) burst_next = 1'b0;
        end
        // a new write to an open bank restarts capture, truncating any burst
        if (cmd == CMD_WRITE && st_reg[ba_s] == B_ACT) begin
            burst_next = 1'b1;
            armed_next = 1'b0;
            rem_next   = blen;
            col_next   = addr_s[COL_W-1:0];
            bk_next    = ba_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            burst_reg  <= 1'b0;
            armed_reg  <= 1'b0;
            rem_reg    <= '0;
            col_reg    <= '0;
            bk_reg     <= '0;
            wr_valid_o <= 1'b0;
            wr_be_o    <= '0;
            wr_bank_o  <= '0;
            wr_col_o   <= '0;
            wr_data_o  <= '0;
        end else begin
            burst_reg  <= burst_next;
            armed_reg  <= armed_next;
            rem_reg    <= rem_next;
            col_reg    <= col_next;
            bk_reg     <= bk_next;
            wr_valid_o <= wv_next;
            wr_be_o    <= wbe_next;
            wr_bank_o  <= wbk_next;
            wr_col_o   <= wc_next;
            wr_data_o  <= wd_next;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_mask_lo;
        l_take && dm_s[0] |=> !wr_be_o[0];
    endproperty
    a_mask_lo: assert property (p_mask_lo) else $error("masked lower byte written");
    property p_upper_lane;
        u_take && !dm_s[1] |=> wr_valid_o && wr_be_o[1] && wr_data_o[15:8] == $past(dq_s[15:8]);
    endproperty
    a_upper_lane: assert property (p_upper_lane) else $error("upper byte not captured");
    property p_preamble;
        burst_reg && !armed_reg && l_edge && !l_rise |=> !wr_be_o[0];
    endproperty
    a_preamble: assert property (p_preamble) else $error("capture on falling preamble");
    property p_write_start;
        cmd == CMD_WRITE && st_reg[ba_s] == B_ACT |=> burst_reg && rem_reg == blen;
    endproperty
    a_write_start: assert property (p_write_start) else $error("write not started");
    property p_rp_hold;
        st_reg[2] == B_PRE && rp_reg[2] != '0 |=> st_reg[2] != B_IDLE;
    endproperty
    a_rp_hold: assert property (p_rp_hold) else $error("bank idle before period");
    property p_pre_nop;
        cmd == CMD_PRE && st_reg[0] == B_IDLE |=> st_reg[0] == B_IDLE;
    endproperty
    a_pre_nop: assert property (p_pre_nop) else $error("precharge of idle bank acted");
    property p_pre_all;
        cmd == CMD_PRE && a10 && st_reg[3] == B_ACT |=> st_reg[3] == B_PRE && rp_reg[3] == precharge_period;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("all-bank precharge missed");
    property p_ap_wait_ras;
        st_reg[2] == B_ACT && ap_reg[2] && ras_reg[2] != '0 && cmd != CMD_PRE
            |=> st_reg[2] == B_ACT;
    endproperty
    a_ap_wait_ras: assert property (p_ap_wait_ras) else $error("auto precharge too early");
    property p_ap_start;
        st_reg[2] == B_ACT && ap_reg[2] && apw_reg[2] == '0 && ras_reg[2] == '0
            |=> st_reg[2] == B_PRE ##1 !ap_reg[2];
    endproperty
    a_ap_start: assert property (p_ap_start) else $error("auto precharge not started");
endmodule
`default_nettype wire

// ==== dv/ddr_ctl_model.sv ====
// behavioural memory controller driving the device's command, data and strobe pins
`timescale 1ns/1ps
`default_nettype none
module ddr_ctl_model
    import ddr_wtp_pkg::*;
(
    // clocks
    input  wire logic                          clk_i,
    input  wire logic                          ck_i,
    // link pins toward the device
    output var logic                           cs_n_o,
    output var logic [2:0]                     cmd_o,
    output var logic [ddr_wtp_pkg::ADDR_W-1:0] addr_o,
    output var logic [1:0]                     bank_o,
    output var logic [ddr_wtp_pkg::DQ_W-1:0]   dq_o,
    output var logic [1:0]                     mask_o,
    output var logic                           strobe_o
);
    initial begin
        cs_n_o   = 1'b1;
        cmd_o    = CMD_NOP;
        addr_o   = 13'h0000;
        bank_o   = 2'h0;
        dq_o     = 16'h0000;
        mask_o   = 2'h3;
        strobe_o = 1'b0;
    end
    // set up on a ck fall, held across the rise; released pins show a changed value
    task automatic command(input cmd_t c, input logic [1:0] b, input logic [12:0] a);
        @(negedge ck_i);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        cmd_o  <= c;
        bank_o <= b;
        addr_o <= a;
        @(negedge ck_i);
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        cmd_o  <= CMD_NOP;
        addr_o <= ~a;
    endtask
    // command meant for another device on the shared bus; this one stays deselected
    task automatic foreign(input cmd_t c, input logic [12:0] a);
        @(negedge ck_i);
        @(posedge clk_i);
        cmd_o  <= c;
        addr_o <= a;
        @(negedge ck_i);
        @(posedge clk_i);
        cmd_o  <= CMD_NOP;
        addr_o <= ~a;
    endtask
    // data is centred on each strobe edge; unwanted slots are still strobed, masked
    task automatic write_burst(input logic [1:0] b, input logic [9:0] col, input logic ap,
                               input int n, input logic [127:0] dv, input logic [15:0] mv);
        command(CMD_WRITE, b, {2'b00, ap, col});
        for (int k = 0; k < n; k++) begin
            repeat (3) @(posedge clk_i);
            dq_o   <= dv[16*k +: 16];
            mask_o <= mv[2*k +: 2];
            repeat (3) @(posedge clk_i);
            strobe_o <= ~strobe_o;
        end
        repeat (3) @(posedge clk_i);
        dq_o   <= ~dq_o;
        mask_o <= ~mask_o;
    endtask
endmodule
`default_nettype wire

// ==== dv/ddr_wr_turnaround_tb.sv ====
// self-checking bench: registers, write capture, precharge and auto precharge
`timescale 1ns/1ps
`default_nettype none
module ddr_wr_turnaround_tb;
    import ddr_wtp_pkg::*;
    logic        clk, rst, cyc, stb, we, ack, ck, cs_n, strobe, wrv;
    logic [3:0]  adr, sel;
    logic [31:0] dat_w, dat_r;
    logic [2:0]  cmd;
    logic [12:0] addr;
    logic [1:0]  bank, mask, wrb, wrbe;
    logic [15:0] dq, wrd;
    logic [9:0]  wrc;
    logic [7:0]  bst;
    logic [29:0] evq[$];
    int          n_errors = 0;
    int          checks_done = 0;
    int          nck = 0;

    ddr_wr_turnaround u_dut (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .ck_i(ck), .cs_n_i(cs_n),
        .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .addr_i(addr),
        .bank_select_low_i(bank[0]), .bank_select_high_i(bank[1]), .dq_i(dq),
        .data_mask_input_i(mask), .lower_byte_strobe_i(strobe), .upper_byte_strobe_i(strobe),
        .wr_valid_o(wrv), .wr_bank_o(wrb), .wr_col_o(wrc), .wr_data_o(wrd), .wr_be_o(wrbe),
        .bank_state_o(bst)
    );
    ddr_ctl_model u_ctl (
        .clk_i(clk), .ck_i(ck), .cs_n_o(cs_n), .cmd_o(cmd), .addr_o(addr), .bank_o(bank),
        .dq_o(dq), .mask_o(mask), .strobe_o(strobe)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // link clock runs free at a twelfth of the clk rate, its edges 1.3 ns after clk edges
    initial begin
        ck = 1'b0;
        #1.3;
        forever #24 ck = ~ck;
    end
    always @(posedge ck) nck <= nck + 1;
    // sampled on the falling clk edge so the registered outputs have settled
    always @(negedge clk) if (wrv === 1'b1) evq.push_back({wrb, wrc, wrd, wrbe});

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // request held until ack is sampled high at a rising edge; the watchdog ends a lost wait
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= s;
        dat_w <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 4'hf, 32'h0, q);
        check(q, exp);
    endtask
    task automatic st(input logic [7:0] exp);
        check({24'h0, bst}, {24'h0, exp});
    endtask
    task automatic at_ck(input int target);
        wait (nck >= target);
        repeat (10) @(posedge clk);
    endtask
    task automatic burst(input logic [1:0] b, input logic [9:0] col, input int n,
                         input logic [15:0] mv, input logic ap);
        logic [127:0] dv;
        int           j;
        for (int k = 0; k < 8; k++) dv[16*k +: 16] = {4'ha, b, col[5:0], 4'(k)};
        evq.delete();
        u_ctl.write_burst(b, col, ap, n, dv, mv);
        repeat (10) @(posedge clk);
        j = 0;
        for (int k = 0; k < n; k++) begin
            if (mv[2*k +: 2] != 2'h3) begin
                if (j < evq.size())
                    check({2'h0, evq[j]}, {2'h0, b, col + 10'(k), dv[16*k +: 16], ~mv[2*k +: 2]});
                j++;
            end
        end
        check(32'(evq.size()), 32'(j));
    endtask

    initial begin
        #200000;
        n_errors++;
        test_done();
    end

    initial begin
        logic [31:0] q;
        int          r;
        rst   = 1'b1;
        cyc   = 1'b0;
        stb   = 1'b0;
        we    = 1'b0;
        adr   = 4'h0;
        sel   = 4'h0;
        dat_w = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(CFG_OFS, {30'h0, BL_RST});
        rdc(TIME_OFS, {8'h00, TWR_RST, ACTIVATE_TO_PRECHARGE_MIN_RST, TRP_RST});
        rdc(STAT_OFS, 32'h0);
        rdc(4'hc, 32'h0);
        wb(1'b1, TIME_OFS, 4'h1, 32'hffffffff, q);
        rdc(TIME_OFS, {8'h00, TWR_RST, ACTIVATE_TO_PRECHARGE_MIN_RST, 8'hff});
        wb(1'b1, STAT_OFS, 4'hf, 32'hffffffff, q);
        rdc(STAT_OFS, 32'h0);
        wb(1'b1, TIME_OFS, 4'hf, {8'h00, TWR_RST, ACTIVATE_TO_PRECHARGE_MIN_RST, TRP_RST}, q);
        for (int b = 1; b < 4; b++) u_ctl.command(CMD_ACT, 2'(b), 13'h0000);
        st({B_ACT, B_ACT, B_ACT, B_IDLE});
        // every burst code, each to another bank, with lane masks on elements 1 to 3
        for (int c = 1; c < 4; c++) begin
            wb(1'b1, CFG_OFS, 4'hf, 32'(c), q);
            burst(2'(c), 10'(16 * c), 1 << c, 16'h00b4, 1'b0);
        end
        burst(2'h1, 10'h200, 8, 16'hfff0, 1'b0);
        burst(2'h1, 10'h300, 8, 16'hfffc, 1'b0);
        u_ctl.foreign(CMD_PRE, 13'h0400);
        st({B_ACT, B_ACT, B_ACT, B_IDLE});
        u_ctl.command(CMD_READ, 2'h1, 13'h0000);
        wb(1'b1, CFG_OFS, 4'hf, {30'h0, BL_CODE_4}, q);
        u_ctl.command(CMD_PRE, 2'h1, 13'h0000);
        r = nck;
        at_ck(r + 2);
        st({B_ACT, B_ACT, B_PRE, B_IDLE});
        at_ck(r + 4);
        st({B_ACT, B_ACT, B_IDLE, B_IDLE});
        u_ctl.command(CMD_PRE, 2'h1, 13'h0000);
        u_ctl.command(CMD_PRE, 2'h1, 13'h0400);
        r = nck;
        at_ck(r + 1);
        st({B_PRE, B_PRE, B_IDLE, B_IDLE});
        u_ctl.command(CMD_PRE, 2'h2, 13'h0000);
        at_ck(r + 4);
        st({B_IDLE, B_IDLE, B_IDLE, B_IDLE});
        u_ctl.command(CMD_ACT, 2'h2, 13'h0000);
        r = nck;
        burst(2'h2, 10'h040, 4, 16'h0000, 1'b1);
        rdc(STAT_OFS, (32'h1 << (ST_AP_LSB + 2)) | {24'h0, B_IDLE, B_ACT, B_IDLE, B_IDLE});
        at_ck(r + 7);
        st({B_IDLE, B_ACT, B_IDLE, B_IDLE});
        u_ctl.command(CMD_ACT, 2'h1, 13'h0000);
        at_ck(r + 10);
        st({B_IDLE, B_PRE, B_ACT, B_IDLE});
        u_ctl.command(CMD_READ, 2'h1, 13'h0400);
        at_ck(r + 13);
        st({B_IDLE, B_IDLE, B_ACT, B_IDLE});
        at_ck(r + 19);
        st({B_IDLE, B_IDLE, B_PRE, B_IDLE});
        at_ck(r + 21);
        st({B_IDLE, B_IDLE, B_IDLE, B_IDLE});
        test_done();
    end
endmodule
`default_nettype wire
